// ===== include/csw_defs.svh
// Functional notes
// - bits 6:4 of the active clock status register show the source now driving the clock.
// - bits 3:0 of the active clock status register show the divider now applied.
// - with switch_hold at 1 a ready requested oscillator is not switched to; the block waits and interrupts.
// - with switch_hold at 0 the switch goes ahead once the requested oscillator is ready, after the new ready flag.
// - switch_hold is read/write, resets to 0 and may also be cleared by the hardware.
// - bit 6 of the switch control register selects high power (1) or low power (0) secondary oscillator.
// - oscillator_ready_flag (bit 4) is 1 when active equals requested and the sequencer is idle, 0 while a switch is in progress.
// - new_oscillator_ready_flag (bit 3) is 1 only while switching with the requested oscillator ready.
// - the new ready flag may rise two clocks after the oscillator is ready; the switch follows next cycle.
// - bit 7 of the status register and bits 5 and 2:0 of the control register read as 0.
`ifndef CSW_DEFS_SVH
`define CSW_DEFS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define CSW_ACT_STATUS_OFS 8'h00
`define CSW_SWITCH_CTRL_OFS 8'h04
`define CSW_REQ_CLOCK_OFS 8'h08
`define CSW_IRQ_STATUS_OFS 8'h0C
`define CSW_IRQ_MASK_OFS 8'h10

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CSW_SRC_MSB 6
`define CSW_SRC_LSB 4
`define CSW_DIV_MSB 3
`define CSW_DIV_LSB 0
`define CSW_HOLD_BIT 7
`define CSW_PWR_BIT 6
`define CSW_OSC_RDY_BIT 4
`define CSW_NEW_RDY_BIT 3
`define CSW_IRQ_HOLD_BIT 0
`define CSW_IRQ_DONE_BIT 1
`define CSW_IRQ_W 2
`define CSW_OSC_N 8

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CSW_RST_SRC 3'h0
`define CSW_RST_DIV 4'h0
`define CSW_RST_HOLD 1'b0
`define CSW_RST_PWR 1'b0

`endif

// ===== include/csw_pkg.sv
package csw_pkg;
  // switch sequencer states, gray along idle -> wait -> ready
  typedef enum logic [1:0] {
    CSW_IDLE  = 2'b00,
    CSW_WAIT  = 2'b01,
    CSW_READY = 2'b11
  } csw_state_t;
endpackage

// ===== rtl/csw_ready_pick.sv
`timescale 1ns/1ps
`include "csw_defs.svh"
module csw_ready_pick (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // oscillator ready lines and selection
  input wire logic [`CSW_OSC_N-1:0] osc_ready,
  input wire logic [2:0] sel,
  // registered ready and the source it belongs to
  output logic ready,
  output logic [2:0] ready_src
);
  typedef struct packed {
    logic ready;
    logic [2:0] src;
  } csw_pick_t;

  csw_pick_t r_reg;
  csw_pick_t r_next;

  always_comb begin
    r_next = r_reg;
    r_next.ready = osc_ready[sel];
    r_next.src = sel;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign ready = r_reg.ready;
  assign ready_src = r_reg.src;
endmodule

// ===== rtl/csw_irq_unit.sv
`timescale 1ns/1ps
`include "csw_defs.svh"
module csw_irq_unit #(
  parameter int W = `CSW_IRQ_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // event pulses
  input wire logic [W-1:0] event_in,
  // software access
  input wire logic wr_status,
  input wire logic wr_mask,
  input wire logic [W-1:0] wdata,
  // state and interrupt
  output logic [W-1:0] status,
  output logic [W-1:0] mask,
  output logic irq
);
  typedef struct packed {
    logic [W-1:0] status;
    logic [W-1:0] mask;
    logic irq;
  } csw_irq_t;

  csw_irq_t r_reg;
  csw_irq_t r_next;

  always_comb begin
    r_next = r_reg;
    // write one clears, a new event wins
    if (wr_status) begin
      r_next.status = r_reg.status & ~wdata;
    end
    r_next.status = r_next.status | event_in;
    if (wr_mask) begin
      r_next.mask = wdata;
    end
    r_next.irq = |(r_next.status & r_next.mask);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign status = r_reg.status;
  assign mask = r_reg.mask;
  assign irq = r_reg.irq;
endmodule

// ===== rtl/csw_clock_switch.sv
// The placing of the registers and the AHB-Lite slave port were decided locally.
`timescale 1ns/1ps
`include "csw_defs.svh"
module csw_clock_switch (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // oscillators
  input wire logic [`CSW_OSC_N-1:0] osc_ready,
  // clock tree control
  output logic [2:0] active_source_code,
  output logic [3:0] active_divider_code,
  output logic secondary_osc_power_select,
  // interrupt
  output logic irq
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    csw_pkg::csw_state_t state;
    logic [2:0] act_src;
    logic [3:0] act_div;
    logic [2:0] req_src;
    logic [3:0] req_div;
    logic hold;
    logic hpwr;
    logic ap_valid;
    logic ap_write;
    logic [7:0] ap_addr;
    logic [31:0] rdata;
  } csw_core_t;

  csw_core_t r_reg;
  csw_core_t r_next;

  logic pick_ready;
  logic [2:0] pick_src;
  logic [`CSW_IRQ_W-1:0] irq_status;
  logic [`CSW_IRQ_W-1:0] irq_mask;
  logic [`CSW_IRQ_W-1:0] events;
  logic wr_phase;
  logic wr_ctrl;
  logic wr_req;
  logic wr_istat;
  logic wr_imask;
  logic switching;
  logic rdy_ok;
  logic oscillator_ready_flag;
  logic new_oscillator_ready_flag;
  logic ev_hold;
  logic ev_done;

  // ----------------------------------------------------------------
  // ready selection and interrupts
  // ----------------------------------------------------------------
  csw_ready_pick u_pick (
    .clk(clk),
    .rst(rst),
    .osc_ready(osc_ready),
    .sel(r_reg.req_src),
    .ready(pick_ready),
    .ready_src(pick_src)
  );

  assign events = {ev_done, ev_hold};

  csw_irq_unit #(
    .W(`CSW_IRQ_W)
  ) u_irq (
    .clk(clk),
    .rst(rst),
    .event_in(events),
    .wr_status(wr_istat),
    .wr_mask(wr_imask),
    .wdata(hwdata[`CSW_IRQ_W-1:0]),
    .status(irq_status),
    .mask(irq_mask),
    .irq(irq)
  );

  // ----------------------------------------------------------------
  // decode and flags
  // ----------------------------------------------------------------
  assign wr_phase = r_reg.ap_valid & r_reg.ap_write;
  assign wr_ctrl = wr_phase && (r_reg.ap_addr == `CSW_SWITCH_CTRL_OFS);
  assign wr_req = wr_phase && (r_reg.ap_addr == `CSW_REQ_CLOCK_OFS);
  assign wr_istat = wr_phase && (r_reg.ap_addr == `CSW_IRQ_STATUS_OFS);
  assign wr_imask = wr_phase && (r_reg.ap_addr == `CSW_IRQ_MASK_OFS);
  assign switching = {r_reg.req_src, r_reg.req_div} != {r_reg.act_src, r_reg.act_div};
  // ready only counts when it belongs to the source now requested
  assign rdy_ok = pick_ready && (pick_src == r_reg.req_src);
  assign oscillator_ready_flag = !switching && (r_reg.state == csw_pkg::CSW_IDLE);
  assign new_oscillator_ready_flag = (r_reg.state == csw_pkg::CSW_READY) && switching
    && rdy_ok;

  function automatic logic [31:0] rd_word(input logic [31:0] a);
    logic [31:0] d;
    d = 32'h0000_0000;
    if (a[31:8] == 24'h00_0000) begin
      case (a[7:0])
        `CSW_ACT_STATUS_OFS: begin
          d[`CSW_SRC_MSB:`CSW_SRC_LSB] = r_reg.act_src;
          d[`CSW_DIV_MSB:`CSW_DIV_LSB] = r_reg.act_div;
        end
        `CSW_SWITCH_CTRL_OFS: begin
          d[`CSW_HOLD_BIT] = r_reg.hold;
          d[`CSW_PWR_BIT] = r_reg.hpwr;
          d[`CSW_OSC_RDY_BIT] = oscillator_ready_flag;
          d[`CSW_NEW_RDY_BIT] = new_oscillator_ready_flag;
        end
        `CSW_REQ_CLOCK_OFS: begin
          d[`CSW_SRC_MSB:`CSW_SRC_LSB] = r_reg.req_src;
          d[`CSW_DIV_MSB:`CSW_DIV_LSB] = r_reg.req_div;
        end
        `CSW_IRQ_STATUS_OFS: begin
          d[`CSW_IRQ_W-1:0] = irq_status;
        end
        `CSW_IRQ_MASK_OFS: begin
          d[`CSW_IRQ_W-1:0] = irq_mask;
        end
        default: begin
          d = 32'h0000_0000;
        end
      endcase
    end
    return d;
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    r_next = r_reg;
    ev_hold = 1'b0;
    ev_done = 1'b0;
    case (r_reg.state)
      csw_pkg::CSW_IDLE: begin
        if (switching) begin
          r_next.state = csw_pkg::CSW_WAIT;
        end
      end
      csw_pkg::CSW_WAIT: begin
        if (!switching) begin
          r_next.state = csw_pkg::CSW_IDLE;
          r_next.hold = 1'b0;
        end else if (rdy_ok) begin
          r_next.state = csw_pkg::CSW_READY;
          ev_hold = r_reg.hold;
        end
      end
      csw_pkg::CSW_READY: begin
        if (!switching) begin
          r_next.state = csw_pkg::CSW_IDLE;
          r_next.hold = 1'b0;
        end else if (!rdy_ok) begin
          r_next.state = csw_pkg::CSW_WAIT;
        end else if (!r_reg.hold) begin
          r_next.act_src = r_reg.req_src;
          r_next.act_div = r_reg.req_div;
          r_next.state = csw_pkg::CSW_IDLE;
          ev_done = 1'b1;
        end
      end
      default: begin
        r_next.state = csw_pkg::CSW_IDLE;
      end
    endcase
    // software write wins over the hardware clear
    if (wr_ctrl) begin
      r_next.hold = hwdata[`CSW_HOLD_BIT];
      r_next.hpwr = hwdata[`CSW_PWR_BIT];
    end
    if (wr_req) begin
      r_next.req_src = hwdata[`CSW_SRC_MSB:`CSW_SRC_LSB];
      r_next.req_div = hwdata[`CSW_DIV_MSB:`CSW_DIV_LSB];
    end
    // address phase capture, read data registered for the data phase
    r_next.ap_valid = hsel && hready && htrans[1];
    r_next.ap_write = hwrite;
    r_next.ap_addr = haddr[31:8] == 24'h00_0000 ? haddr[7:0] : 8'hFF;
    if (hsel && hready && htrans[1] && !hwrite) begin
      r_next.rdata = rd_word(haddr);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      r_reg <= '0;
      r_reg.state <= csw_pkg::CSW_IDLE;
      r_reg.act_src <= `CSW_RST_SRC;
      r_reg.act_div <= `CSW_RST_DIV;
      r_reg.req_src <= `CSW_RST_SRC;
      r_reg.req_div <= `CSW_RST_DIV;
      r_reg.hold <= `CSW_RST_HOLD;
      r_reg.hpwr <= `CSW_RST_PWR;
    end else begin
      r_reg <= r_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = r_reg.rdata;
  assign active_source_code = r_reg.act_src;
  assign active_divider_code = r_reg.act_div;
  assign secondary_osc_power_select = r_reg.hpwr;

  // ----------------------------------------------------------------
  // assertions: register reads
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  logic rd_act;
  logic rd_ctrl;
  assign rd_act = r_reg.ap_valid && !r_reg.ap_write && r_reg.ap_addr == `CSW_ACT_STATUS_OFS;
  assign rd_ctrl = r_reg.ap_valid && !r_reg.ap_write && r_reg.ap_addr == `CSW_SWITCH_CTRL_OFS;

  src_read_a: assert property (rd_act |-> hrdata[6:4] == $past(r_reg.act_src))
    else $error("active source field wrong");
  div_read_a: assert property (rd_act |-> hrdata[3:0] == $past(r_reg.act_div))
    else $error("active divider field wrong");
  hold_read_a: assert property (rd_ctrl |-> hrdata[7] == $past(r_reg.hold))
    else $error("hold bit read wrong");
  power_read_a: assert property (rd_ctrl |-> hrdata[6] == $past(r_reg.hpwr))
    else $error("power select read wrong");
  ready_read_a: assert property (rd_ctrl |-> hrdata[4] == $past(oscillator_ready_flag))
    else $error("ready flag read wrong");
  new_ready_read_a: assert property (rd_ctrl |->
    hrdata[3] == $past(new_oscillator_ready_flag))
    else $error("new ready flag read wrong");
  unused_zero_a: assert property ((rd_act |-> hrdata[7] == 1'b0) and
    (rd_ctrl |-> hrdata[5] == 1'b0 && hrdata[2:0] == 3'h0))
    else $error("unused bits not zero");

  // ----------------------------------------------------------------
  // assertions: register writes and bus response
  // ----------------------------------------------------------------
  hold_write_a: assert property (wr_ctrl |=> r_reg.hold == $past(hwdata[7]))
    else $error("hold bit write lost");
  power_write_a: assert property (wr_ctrl |=> secondary_osc_power_select == $past(hwdata[6]))
    else $error("power select write lost");
  req_write_a: assert property (wr_req |=>
    r_reg.req_src == $past(hwdata[6:4]) && r_reg.req_div == $past(hwdata[3:0]))
    else $error("requested clock write lost");
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus response not okay");

  // ----------------------------------------------------------------
  // assertions: switch sequencer
  // ----------------------------------------------------------------
  hold_blocks_a: assert property (new_oscillator_ready_flag && r_reg.hold |=>
    $stable(active_source_code) && $stable(active_divider_code))
    else $error("switch completed under hold");
  hold_event_a: assert property (r_reg.state == csw_pkg::CSW_WAIT && switching && rdy_ok
    && r_reg.hold |=> irq_status[`CSW_IRQ_HOLD_BIT])
    else $error("held switch event missing");
  irq_level_a: assert property (|(irq_status & irq_mask) |-> irq)
    else $error("interrupt low with unmasked event");
  switch_next_a: assert property (new_oscillator_ready_flag && !r_reg.hold && rdy_ok |=>
    active_source_code == $past(r_reg.req_src) && !new_oscillator_ready_flag)
    else $error("switch did not follow ready");
  act_stable_a: assert property (!new_oscillator_ready_flag |=>
    $stable(active_source_code) && $stable(active_divider_code))
    else $error("active clock changed without a ready switch");
  done_event_a: assert property (new_oscillator_ready_flag && !r_reg.hold |=>
    irq_status[`CSW_IRQ_DONE_BIT])
    else $error("switch done event missing");
  hold_clear_a: assert property (r_reg.state != csw_pkg::CSW_IDLE && !switching && !wr_ctrl |=>
    !r_reg.hold)
    else $error("hold not cleared on abandoned switch");
  ready_flag_busy_a: assert property (switching |-> !oscillator_ready_flag)
    else $error("ready flag high during switch");
  ready_flag_idle_a: assert property (!switching ##1 !switching |-> oscillator_ready_flag)
    else $error("ready flag low with requested clock in use");
  new_flag_cause_a: assert property (new_oscillator_ready_flag |->
    switching && $past(osc_ready[r_reg.req_src]))
    else $error("new ready flag without cause");
  new_flag_latency_a: assert property (r_reg.state == csw_pkg::CSW_WAIT && !wr_req
    && osc_ready[r_reg.req_src] ##1 !wr_req && osc_ready[r_reg.req_src] |->
    ##[0:1] (new_oscillator_ready_flag || r_reg.state == csw_pkg::CSW_IDLE))
    else $error("new ready flag late");

  // ----------------------------------------------------------------
  // cover points
  // ----------------------------------------------------------------
  switch_done_c: cover property (new_oscillator_ready_flag ##1 oscillator_ready_flag);
  held_switch_c: cover property (new_oscillator_ready_flag && r_reg.hold [*3]);
  irq_raised_c: cover property ($rose(irq));
  abort_c: cover property (r_reg.state == csw_pkg::CSW_WAIT && !switching);
  held_release_c: cover property (new_oscillator_ready_flag && r_reg.hold ##1 !r_reg.hold);
endmodule

// ===== sim/test_clock_switch_status_control.sv
`timescale 1ns/1ps
`include "csw_defs.svh"
module test_clock_switch_status_control;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  localparam logic [31:0] A_ST = {24'h00_0000, `CSW_ACT_STATUS_OFS};
  localparam logic [31:0] A_CT = {24'h00_0000, `CSW_SWITCH_CTRL_OFS};
  localparam logic [31:0] A_RQ = {24'h00_0000, `CSW_REQ_CLOCK_OFS};
  localparam logic [31:0] A_IS = {24'h00_0000, `CSW_IRQ_STATUS_OFS};
  localparam logic [31:0] A_IM = {24'h00_0000, `CSW_IRQ_MASK_OFS};
  logic clk, rst, hsel, hwrite, hreadyout, hresp, irq, pwr_o, pw;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize, act_src, src, cur_src;
  logic [3:0] act_div, div, cur_div;
  logic [7:0] osc_ready;
  int errors, checks, seed, n;

  csw_clock_switch csw_clock_switch_i (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .osc_ready(osc_ready),
    .active_source_code(act_src), .active_divider_code(act_div),
    .secondary_osc_power_select(pwr_o), .irq(irq));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // tasks and expectations
  // ----------------------------------------------------------------
  function automatic logic [31:0] ctl(logic h, logic p, logic o, logic nr);
    return {24'h00_0000, h, p, 1'b0, o, nr, 3'h0};
  endfunction
  function automatic logic [31:0] stv(logic [2:0] s, logic [3:0] d);
    return {24'h00_0000, 1'b0, s, d};
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rc(input string nm, input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    chk(nm, rd, exp);
  endtask
  task automatic wait_switch();
    n = 0;
    while (act_src !== src && n < 20) begin
      @(posedge clk);
      n++;
    end
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    stop_test();
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    seed = 99991;
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    osc_ready = 8'h00;
    errors = 0;
    checks = 0;
    cur_src = 3'h0;
    cur_div = 4'h0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rc("status", A_ST, stv(3'h0, 4'h0));
    rc("control", A_CT, ctl(1'b0, 1'b0, 1'b1, 1'b0));
    rc("irq status", A_IS, 32'h0000_0000);
    rc("unmapped", 32'h0000_0014, 32'h0000_0000);
    wr(A_CT, 32'h0000_00ff);
    rc("control bits", A_CT, ctl(1'b1, 1'b1, 1'b1, 1'b0));
    chk("power port", 32'(pwr_o), 32'h0000_0001);
    wr(A_CT, 32'h0000_0000);
    $display("reset and access test done");
    for (int i = 0; i < 4; i++) begin
      src = 3'($random(seed));
      if (src == cur_src) src = src + 3'h1;
      div = 4'($random(seed));
      pw = 1'($random(seed));
      osc_ready <= 8'($random(seed)) & ~(8'h01 << src);
      wr(A_CT, {24'h00_0000, 1'b0, pw, 6'h00});
      wr(A_RQ, stv(src, div));
      rc("pending control", A_CT, ctl(1'b0, pw, 1'b0, 1'b0));
      chk("no early switch", 32'(act_src), 32'(cur_src));
      chk("power port", 32'(pwr_o), 32'(pw));
      osc_ready <= osc_ready | (8'h01 << src);
      wait_switch();
      chk("switch latency", 32'(n <= 4), 32'h0000_0001);
      chk("divider port", 32'(act_div), 32'(div));
      rc("switched status", A_ST, stv(src, div));
      rc("switched control", A_CT, ctl(1'b0, pw, 1'b1, 1'b0));
      rc("done event", A_IS, 32'h0000_0002);
      wr(A_IS, 32'h0000_0003);
      cur_src = src;
      cur_div = div;
      osc_ready <= 8'h00;
    end
    $display("random switch test done");
    wr(A_IM, 32'h0000_0003);
    wr(A_CT, 32'h0000_0080);
    src = cur_src + 3'h1;
    wr(A_RQ, stv(src, 4'h5));
    osc_ready <= 8'hff;
    repeat (8) @(posedge clk);
    chk("held source", 32'(act_src), 32'(cur_src));
    rc("held control", A_CT, ctl(1'b1, 1'b0, 1'b0, 1'b1));
    chk("held irq", 32'(irq), 32'h0000_0001);
    rc("hold event", A_IS, 32'h0000_0001);
    wr(A_IS, 32'h0000_0001);
    repeat (2) @(posedge clk);
    chk("irq cleared", 32'(irq), 32'h0000_0000);
    wr(A_CT, 32'h0000_0000);
    wait_switch();
    chk("released switch", 32'(act_src), 32'(src));
    rc("released event", A_IS, 32'h0000_0002);
    repeat (2) @(posedge clk);
    chk("done irq", 32'(irq), 32'h0000_0001);
    wr(A_IS, 32'h0000_0003);
    wr(A_IM, 32'h0000_0000);
    cur_src = src;
    cur_div = 4'h5;
    $display("hold test done");
    osc_ready <= 8'h00;
    wr(A_CT, 32'h0000_0080);
    wr(A_RQ, stv(cur_src + 3'h1, cur_div));
    wr(A_RQ, stv(cur_src, cur_div));
    repeat (2) @(posedge clk);
    rc("hardware hold clear", A_CT, ctl(1'b0, 1'b0, 1'b1, 1'b0));
    chk("aborted source", 32'(act_src), 32'(cur_src));
    $display("abort test done");
    wr(A_CT, 32'h0000_00c0);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rc("reset control", A_CT, ctl(1'b0, 1'b0, 1'b1, 1'b0));
    rc("reset status", A_ST, stv(3'h0, 4'h0));
    chk("reset power port", 32'(pwr_o), 32'h0000_0000);
    $display("mid-run reset test done");
    stop_test();
  end
endmodule
